// file: design/lpm_mode_ctrl.sv
// Low-power mode controller: run, sleep, stop and standby sequencing,
// oscillator and regulator controls, flash wait states, wake timing.
// Assumes all inputs synchronous to sys_clk and wait_req a one-cycle pulse.
//
// Summary of operation
// - Three ranges: 32, 16, 4.2 MHz ceilings
// - Sleep halts only CPU clock
// - Low-power run: slow multispeed osc, LP regulator
// - LP sleep wakes to run, regulator on
// - Stop with RTC keeps low-speed osc
// - Stop without RTC or watchdog stops all clocks except a peripheral-requested high-speed internal
// - Peripherals may request high-speed internal in Stop
// - Interrupt line wakes Stop within 3.5 us
// - Stop wake source list, comparator two gated
// - Standby: regulator and fast oscillators off
// - Standby loses core state, keeps standby domain
// - Standby with RTC exits in 60 us
// - Standby without RTC: reset or pins
// - RTC and watchdog clocks not auto-stopped
// - Wait states follow range and frequency
`timescale 1ns/1ns
module lpm_mode_ctrl
    import lpm_pkg::*;
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // Software controls
    input  wire logic                  wait_req,
    input  wire logic [1:0]            mode_sel,
    input  wire logic                  lp_run_req,
    input  wire logic [1:0]            range_sel,
    input  wire logic [15:0]           cpu_freq_khz,
    input  wire logic                  rtc_en,
    input  wire logic                  independent_watchdog_en,
    input  wire logic                  vref_on,
    input  wire logic                  standby_flag_clr,
    // Run-mode oscillator requests
    input  wire logic                  pll_req,
    input  wire logic                  ms_osc_req,
    input  wire logic                  hs_ext_clk_req,
    input  wire logic                  hs_int_osc_req,
    input  wire logic                  ls_ext_osc_req,
    input  wire logic                  ls_int_osc_req,
    // Wake sources
    input  wire logic                  irq_pending,
    input  wire logic [LPM_GPIO_W-1:0] gpio_line,
    input  wire logic                  voltage_detector_out,
    input  wire logic                  comp1_evt,
    input  wire logic                  comp2_evt,
    input  wire logic                  serial_wake,
    input  wire logic                  i2c_wake,
    input  wire logic                  low_power_serial_port_wake,
    input  wire logic                  low_power_timer_wake,
    input  wire logic [LPM_RTC_W-1:0]  rtc_evt,
    input  wire logic [LPM_WKP_W-1:0]  wakeup_pin,
    input  wire logic                  external_reset_pin_n,
    input  wire logic                  independent_watchdog_reset,
    input  wire logic                  periph_hs_osc_req,
    // Clock and power controls
    output logic                       cpu_clk_en,
    output logic                       periph_clk_en,
    output logic                       regulator_lp,
    output logic                       regulator_off,
    output logic                       pll_en,
    output logic                       multispeed_internal_osc_en,
    output logic                       high_speed_external_clock_en,
    output logic                       high_speed_internal_osc_en,
    output logic                       low_speed_external_osc_en,
    output logic                       low_speed_internal_osc_en,
    output logic                       ram_retain,
    output logic                       core_reset_n,
    // Status
    output logic [2:0]                 power_state,
    output logic                       flash_wait_state,
    output logic                       freq_over_limit,
    output logic                       standby_flag
);

    lpm_state_type state_q;         // Current power state
    lpm_state_type state_d;         // Next power state
    logic          from_stby_q;     // Wake in progress came from standby
    logic          from_stby_d;
    logic          ws_q;            // Flash wait state
    logic          over_q;          // Frequency above range ceiling
    logic          sbf_q;           // Standby flag, kept in standby domain
    logic [LPM_WKP_W-1:0] wkp_prev_q;   // Wakeup pins last cycle

    // Wait-state decision from range and frequency
    function automatic logic need_ws(input logic [1:0] rng, input logic [15:0] khz);
        logic r;
        r = 1'b0;
        case (rng)
            LPM_RANGE1: r = (khz > LPM_R1_WS_KHZ);
            LPM_RANGE2: r = (khz > LPM_R2_WS_KHZ);
            default:    r = 1'b0;
        endcase
        return r;
    endfunction

    // Ceiling of each range
    function automatic logic [15:0] range_max(input logic [1:0] rng);
        logic [15:0] m;
        m = LPM_R3_MAX_KHZ;
        case (rng)
            LPM_RANGE1: m = LPM_R1_MAX_KHZ;
            LPM_RANGE2: m = LPM_R2_MAX_KHZ;
            default:    m = LPM_R3_MAX_KHZ;
        endcase
        return m;
    endfunction

    // Event decoding
    wire rtc_wake    = rtc_en && (|rtc_evt);
    wire comp2_ok    = comp2_evt && vref_on;
    wire stop_wake   = (|gpio_line) || voltage_detector_out || comp1_evt
                     || comp2_ok || serial_wake || i2c_wake
                     || low_power_serial_port_wake || low_power_timer_wake
                     || rtc_wake;
    wire [LPM_WKP_W-1:0] wkp_rise = wakeup_pin & ~wkp_prev_q;
    wire stby_base   = !external_reset_pin_n || (|wkp_rise);
    wire stby_wake   = stby_base || (rtc_en && (independent_watchdog_reset || rtc_wake));
    wire lprun_ok    = lp_run_req && (cpu_freq_khz <= LPM_LPRUN_MAX_KHZ);

    // Timer strobes
    wire           tmr_done, tmr_busy;
    wire           go_stop_wake = (state_q == LPM_STOP) && stop_wake;
    wire           go_stby_wake = (state_q == LPM_STANDBY) && stby_wake;
    wire           tmr_load     = go_stop_wake || go_stby_wake;
    wire [LPM_CNT_W-1:0] tmr_val = go_stby_wake ? STANDBY_WAKE_LOAD : STOP_WAKE_LOAD;

    // Wake latency timer
    lpm_wake_timer lpm_wake_timer_inst (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .load     (tmr_load),
        .load_val (tmr_val),
        .busy     (tmr_busy),
        .done     (tmr_done)
    );

    // Next-state logic; mode is taken from settings at the wait pulse
    always_comb begin
        state_d     = state_q;
        from_stby_d = from_stby_q;
        case (state_q)
            LPM_RUN, LPM_LPRUN: begin
                if (wait_req) begin
                    case (mode_sel)
                        LPM_SEL_STOP:    state_d = LPM_STOP;
                        LPM_SEL_STANDBY: state_d = LPM_STANDBY;
                        default:         state_d = (state_q == LPM_LPRUN) ?
                                                   LPM_LPSLEEP : LPM_SLEEP;
                    endcase
                end else if (state_q == LPM_RUN && lprun_ok) begin
                    state_d = LPM_LPRUN;
                end else if (state_q == LPM_LPRUN && !lp_run_req) begin
                    state_d = LPM_RUN;
                end
            end
            LPM_SLEEP: begin
                if (irq_pending) state_d = LPM_RUN;
            end
            LPM_LPSLEEP: begin
                if (irq_pending) state_d = LPM_RUN;
            end
            LPM_STOP: begin
                if (stop_wake) begin
                    state_d     = LPM_WAKE;
                    from_stby_d = 1'b0;
                end
            end
            LPM_STANDBY: begin
                if (stby_wake) begin
                    state_d     = LPM_WAKE;
                    from_stby_d = 1'b1;
                end
            end
            LPM_WAKE: begin
                if (tmr_done) begin
                    state_d     = LPM_RUN;
                    from_stby_d = 1'b0;
                end
            end
            default: state_d = LPM_RUN;
        endcase
    end

    // Mode decoding for outputs
    wire in_stop   = (state_q == LPM_STOP);
    wire in_stby   = (state_q == LPM_STANDBY);
    wire stby_wake_phase = (state_q == LPM_WAKE) && from_stby_q;
    wire deep      = in_stop || in_stby;
    wire slow_keep = rtc_en || independent_watchdog_en;

    assign cpu_clk_en    = (state_q == LPM_RUN) || (state_q == LPM_LPRUN);
    assign periph_clk_en = !deep && (state_q != LPM_WAKE);
    assign regulator_lp  = (state_q == LPM_LPRUN) || (state_q == LPM_LPSLEEP)
                         || in_stop;
    assign regulator_off = in_stby;
    assign pll_en        = pll_req && !deep;
    assign multispeed_internal_osc_en   = (ms_osc_req || regulator_lp) && !deep;
    assign high_speed_external_clock_en = hs_ext_clk_req && !deep;
    assign high_speed_internal_osc_en   = in_stop ? periph_hs_osc_req
                                        : (hs_int_osc_req && !in_stby);
    assign low_speed_external_osc_en    = ls_ext_osc_req && (!deep || slow_keep);
    assign low_speed_internal_osc_en    = ls_int_osc_req && (!deep || slow_keep);
    assign ram_retain    = !in_stby && !stby_wake_phase;
    assign core_reset_n  = !in_stby && !stby_wake_phase;
    assign power_state   = state_q;
    assign flash_wait_state = ws_q;
    assign freq_over_limit  = over_q;
    assign standby_flag     = sbf_q;

    // State and edge registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= LPM_RUN;
            from_stby_q <= 1'b0;
            wkp_prev_q  <= '0;
        end else begin
            state_q     <= state_d;
            from_stby_q <= from_stby_d;
            wkp_prev_q  <= wakeup_pin;
        end
    end

    // Wait states, ceiling check, standby flag (entry wins over clear)
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ws_q   <= 1'b0;
            over_q <= 1'b0;
            sbf_q  <= 1'b0;
        end else begin
            ws_q   <= need_ws(range_sel, cpu_freq_khz);
            over_q <= (cpu_freq_khz > range_max(range_sel));
            sbf_q  <= in_stby || (sbf_q && !standby_flag_clr);
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_SLEEP_CLK: assert property (
        (state_q == LPM_SLEEP) |-> (!cpu_clk_en && periph_clk_en))
        else $error("Sleep must halt only the CPU clock");
    AST_LPRUN_OSC: assert property (
        (state_q == LPM_LPRUN) |-> (regulator_lp && multispeed_internal_osc_en && cpu_clk_en))
        else $error("Low-power run state inconsistent");
    AST_LPRUN_REFUSE: assert property (
        (state_q == LPM_RUN && lp_run_req && !wait_req && cpu_freq_khz > LPM_LPRUN_MAX_KHZ)
        |=> (state_q == LPM_RUN))
        else $error("Low-power run entered above its clock ceiling");
    AST_LPSLEEP_RET: assert property (
        (state_q == LPM_LPSLEEP && irq_pending) |=> (state_q == LPM_RUN && !regulator_lp))
        else $error("Low-power sleep did not return to run");
    AST_STOP_OSC: assert property (
        in_stop |-> (!pll_en && !multispeed_internal_osc_en
                     && !high_speed_external_clock_en && regulator_lp && ram_retain))
        else $error("Stop left a fast clock running");
    AST_STOP_NORTC: assert property (
        (in_stop && !rtc_en && !independent_watchdog_en) |->
            (!low_speed_external_osc_en && !low_speed_internal_osc_en))
        else $error("Stop without clock kept slow oscillator");
    AST_FAST_OSC_REQ: assert property (
        in_stop |-> (high_speed_internal_osc_en == periph_hs_osc_req))
        else $error("Stop ignored high-speed request");
    AST_STOP_WAKE: assert property (
        (in_stop && stop_wake) |-> ##35 (state_q == LPM_RUN && cpu_clk_en))
        else $error("Stop wake latency wrong");
    AST_COMP2_GATE: assert property (
        (in_stop && comp2_evt && !vref_on && !(|gpio_line) && !voltage_detector_out
         && !comp1_evt && !serial_wake && !i2c_wake && !low_power_serial_port_wake
         && !low_power_timer_wake && !rtc_wake) |=> in_stop)
        else $error("Comparator two woke without reference");
    AST_STBY_PWR: assert property (
        in_stby |-> (regulator_off && !pll_en && !high_speed_internal_osc_en
                     && !core_reset_n && !ram_retain))
        else $error("Standby power controls wrong");
    AST_STBY_WAKE: assert property (
        (in_stby && stby_wake) |=> (!core_reset_n) [*8] ##[1:592] core_reset_n)
        else $error("Standby exit latency wrong");
    AST_STBY_NORTC: assert property (
        (in_stby && !rtc_en && !stby_base) |=> in_stby)
        else $error("Standby left without pin or reset");
    AST_WAIT_STATE: assert property (
        (range_sel == LPM_RANGE1 && cpu_freq_khz > LPM_R1_WS_KHZ) ##1
        (range_sel == LPM_RANGE3) |-> flash_wait_state ##1 !flash_wait_state)
        else $error("Flash wait state not following range");
    AST_WAKE_TIMER: assert property (
        (state_q == LPM_WAKE) |-> tmr_busy)
        else $error("Wake state without a running latency timer");

endmodule // lpm_mode_ctrl

// file: design/lpm_wake_timer.sv
// Down counter that times the wake latency of the controller.
// Assumes load value of at least one; done pulses on the last cycle.
`timescale 1ns/1ns
module lpm_wake_timer
    import lpm_pkg::*;
(
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    // Control
    input  wire logic                 load,
    input  wire logic [LPM_CNT_W-1:0] load_val,
    // Status
    output logic                      busy,
    output logic                      done
);

    logic [LPM_CNT_W-1:0] cnt_q;    // Remaining cycles
    logic [LPM_CNT_W-1:0] cnt_d;    // Next count

    // Reload wins over counting so a fresh wake restarts cleanly
    assign cnt_d = load ? load_val :
                   (cnt_q != LPM_CNT_ZERO) ? cnt_q - LPM_CNT_ONE : LPM_CNT_ZERO;
    assign busy  = (cnt_q != LPM_CNT_ZERO);
    assign done  = (cnt_q == LPM_CNT_ONE) && !load;

    // Count register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= LPM_CNT_ZERO;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule // lpm_wake_timer

// file: pkg/lpm_pkg.sv
// Constants for the low-power mode controller: states, mode selects,
// frequency ceilings, wait-state thresholds and wake latencies.
// Assumes a 10 MHz system clock and frequencies given in kHz.
package lpm_pkg;

    // Power state machine
    typedef enum logic [2:0] {
        LPM_RUN     = 3'b000,
        LPM_LPRUN   = 3'b001,
        LPM_SLEEP   = 3'b010,
        LPM_LPSLEEP = 3'b011,
        LPM_STOP    = 3'b100,
        LPM_STANDBY = 3'b101,
        LPM_WAKE    = 3'b110
    } lpm_state_type;

    // Target mode chosen before the wait instruction
    localparam logic [1:0] LPM_SEL_SLEEP   = 2'h0;
    localparam logic [1:0] LPM_SEL_STOP    = 2'h1;
    localparam logic [1:0] LPM_SEL_STANDBY = 2'h2;

    // Voltage scaling ranges
    localparam logic [1:0] LPM_RANGE1 = 2'h1;
    localparam logic [1:0] LPM_RANGE2 = 2'h2;
    localparam logic [1:0] LPM_RANGE3 = 2'h3;

    // Frequency ceilings in kHz
    localparam logic [15:0] LPM_R1_MAX_KHZ    = 16'd32000;
    localparam logic [15:0] LPM_R2_MAX_KHZ    = 16'd16000;
    localparam logic [15:0] LPM_R3_MAX_KHZ    = 16'd4200;
    localparam logic [15:0] LPM_LPRUN_MAX_KHZ = 16'd131;

    // Above these a flash wait state is needed
    localparam logic [15:0] LPM_R1_WS_KHZ = 16'd16000;
    localparam logic [15:0] LPM_R2_WS_KHZ = 16'd8000;

    // Widths of event groups and of the wake counter
    localparam int LPM_GPIO_W = 16;
    localparam int LPM_RTC_W  = 5;
    localparam int LPM_WKP_W  = 3;
    localparam int LPM_CNT_W  = 10;

    // Wake latencies, longest times round down
    localparam int CLK_PERIOD_NS     = 100;
    localparam int STOP_WAKE_NS      = 3500;
    localparam int STANDBY_WAKE_NS   = 60000;
    localparam int STOP_WAKE_CYC     = STOP_WAKE_NS / CLK_PERIOD_NS;
    localparam int STANDBY_WAKE_CYC  = STANDBY_WAKE_NS / CLK_PERIOD_NS;
    // Timer load: state change takes one cycle of its own
    localparam logic [LPM_CNT_W-1:0] STOP_WAKE_LOAD    = LPM_CNT_W'(STOP_WAKE_CYC - 1);
    localparam logic [LPM_CNT_W-1:0] STANDBY_WAKE_LOAD = LPM_CNT_W'(STANDBY_WAKE_CYC - 1);
    localparam logic [LPM_CNT_W-1:0] LPM_CNT_ONE       = LPM_CNT_W'(1);
    localparam logic [LPM_CNT_W-1:0] LPM_CNT_ZERO      = '0;

endpackage

// file: testbench/lpm_core_model.sv
// Core-side model: issues wait requests and steps the CPU clock.
// Assumes a free-running sys_clk and one calling process at a time.
`timescale 1ns/1ns
module lpm_core_model
    import lpm_pkg::*;
(
    // Clock
    input  wire logic  sys_clk,
    // Requests to the controller
    output logic        wait_req,
    output logic [1:0]  mode_sel,
    output logic [15:0] cpu_freq_khz
);
    // Idle at time zero, slow clock
    initial begin
        wait_req = 1'b0;
        mode_sel = LPM_SEL_SLEEP;
        cpu_freq_khz = 16'h07D0;
    end

    // Mode settles a cycle before the one-cycle wait pulse
    task automatic issue_wait(input logic [1:0] sel);
        @(negedge sys_clk) mode_sel = sel;
        @(negedge sys_clk) wait_req = 1'b1;
        @(negedge sys_clk) wait_req = 1'b0;
    endtask

    // Under 4x per step, 51 cycles apart; large jumps go in stages
    task automatic set_freq(input logic [15:0] f);
        while (32'(f) >= 4 * 32'(cpu_freq_khz)) begin
            @(negedge sys_clk) cpu_freq_khz = 16'(4 * 32'(cpu_freq_khz) - 1);
            repeat (50) @(negedge sys_clk);
        end
        @(negedge sys_clk) cpu_freq_khz = f;
        repeat (50) @(negedge sys_clk);
    endtask
endmodule // lpm_core_model

// file: testbench/tb_low_power_mode_controller.sv
// Bench for the low-power mode controller: mode entry, wake sources,
// wake latency and flash wait states. Assumes the core model drives
// wait_req, mode_sel and cpu_freq_khz; the rest is driven here.
`timescale 1ns/1ns
module tb_low_power_mode_controller
    import lpm_pkg::*;
;
    // Clock, reset and tallies
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    int          fail_count = 0;
    int          n_checks = 0;
    int          cycles = 0;
    // Software and oscillator controls
    logic        lp_run_req, rtc_en, independent_watchdog_en, vref_on, standby_flag_clr;
    logic [1:0]  range_sel;
    logic [5:0]  osc_req;   // Pll, multispeed, fast ext, fast int, slow ext, slow int
    // Wake sources
    logic        irq_pending, external_reset_pin_n, periph_hs_osc_req;
    logic        independent_watchdog_reset;
    logic [6:0]  single_ev; // Detector, comp1, comp2, serial, i2c, lp port, lp timer
    logic [15:0] gpio_line;
    logic [4:0]  rtc_evt;
    logic [2:0]  wakeup_pin;
    // Core model and controller outputs
    logic        wait_req;
    logic [1:0]  mode_sel;
    logic [15:0] cpu_freq_khz;
    logic        cpu_clk_en, periph_clk_en, regulator_lp, regulator_off, pll_en;
    logic        multispeed_internal_osc_en, high_speed_external_clock_en;
    logic        high_speed_internal_osc_en, low_speed_external_osc_en;
    logic        low_speed_internal_osc_en, ram_retain, core_reset_n;
    logic [2:0]  power_state;
    logic        flash_wait_state, freq_over_limit, standby_flag;

    // Units under test
    lpm_core_model lpm_core_model_inst (.sys_clk, .wait_req, .mode_sel, .cpu_freq_khz);
    lpm_mode_ctrl lpm_mode_ctrl_inst (
        .sys_clk, .rst_n, .wait_req, .mode_sel, .lp_run_req, .range_sel,
        .cpu_freq_khz, .rtc_en, .independent_watchdog_en, .vref_on, .standby_flag_clr,
        .pll_req(osc_req[5]), .ms_osc_req(osc_req[4]), .hs_ext_clk_req(osc_req[3]),
        .hs_int_osc_req(osc_req[2]), .ls_ext_osc_req(osc_req[1]), .ls_int_osc_req(osc_req[0]),
        .irq_pending, .gpio_line, .voltage_detector_out(single_ev[0]),
        .comp1_evt(single_ev[1]), .comp2_evt(single_ev[2]), .serial_wake(single_ev[3]),
        .i2c_wake(single_ev[4]), .low_power_serial_port_wake(single_ev[5]),
        .low_power_timer_wake(single_ev[6]), .rtc_evt, .wakeup_pin,
        .external_reset_pin_n, .independent_watchdog_reset, .periph_hs_osc_req, .cpu_clk_en,
        .periph_clk_en, .regulator_lp, .regulator_off, .pll_en,
        .multispeed_internal_osc_en, .high_speed_external_clock_en,
        .high_speed_internal_osc_en, .low_speed_external_osc_en,
        .low_speed_internal_osc_en, .ram_retain, .core_reset_n, .power_state,
        .flash_wait_state, .freq_over_limit, .standby_flag);

    // 10 MHz clock
    always #50 sys_clk = ~sys_clk;

    // Hang guard, well above the few thousand cycles needed
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end

    // Compare and tally
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // All wake sources quiet
    task automatic clear_ev();
        {irq_pending, independent_watchdog_reset, periph_hs_osc_req} = 3'h0;
        external_reset_pin_n = 1'b1;
        single_ev = 7'h00;
        gpio_line = 16'h0000;
        rtc_evt = 5'h00;
        wakeup_pin = 3'h0;
    endtask

    // Event already driven: WAKE until cycle n, RUN from it
    task automatic wait_run(input int n, input logic exp_rst);
        @(negedge sys_clk);
        clear_ev();
        repeat (n - 2) @(negedge sys_clk);
        chk(power_state, LPM_WAKE);
        chk(core_reset_n, exp_rst);
        @(negedge sys_clk);
        chk(power_state, LPM_RUN);
    endtask

    // Wait state and ceiling per range, at the boundaries
    task automatic t_flash();
        logic [15:0] fq [7] = '{16'h1068, 16'h1F40, 16'h1F41, 16'h3E81, 16'h3E80,
                                16'h3E81, 16'h7D01};
        logic [1:0]  rg [7] = '{2'h3, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1};
        logic [1:0]  ex [7] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h0, 2'h2, 2'h3};
        for (int i = 0; i < 7; i++) begin
            range_sel = rg[i];
            lpm_core_model_inst.set_freq(fq[i]);
            chk({flash_wait_state, freq_over_limit}, ex[i]);
        end
        range_sel = LPM_RANGE3;
        lpm_core_model_inst.set_freq(16'h1069);
        chk(freq_over_limit, 1'b1);
        // Range code zero behaves as the slowest range
        range_sel = 2'h0;
        repeat (2) @(negedge sys_clk);
        chk({flash_wait_state, freq_over_limit}, 2'h1);
    endtask

    // Refused above 131 kHz, then low-power run and sleep
    task automatic t_lprun();
        osc_req = 6'h00;
        lp_run_req = 1'b1;
        lpm_core_model_inst.set_freq(16'h0084);
        chk(power_state, LPM_RUN);
        lpm_core_model_inst.set_freq(16'h0083);
        chk(power_state, LPM_LPRUN);
        chk({regulator_lp, multispeed_internal_osc_en, cpu_clk_en}, 3'h7);
        lpm_core_model_inst.issue_wait(LPM_SEL_SLEEP);
        chk(power_state, LPM_LPSLEEP);
        lp_run_req = 1'b0;
        irq_pending = 1'b1;
        @(negedge sys_clk);
        irq_pending = 1'b0;
        chk({power_state, regulator_lp}, {LPM_RUN, 1'b0});
        osc_req = 6'h3F;
    endtask

    // Sleep halts only the CPU clock; select code three also means sleep
    task automatic t_sleep();
        lpm_core_model_inst.issue_wait(2'h3);
        chk(power_state, LPM_SLEEP);
        chk({cpu_clk_en, periph_clk_en, pll_en, regulator_lp}, 4'h6);
        irq_pending = 1'b1;
        @(negedge sys_clk);
        irq_pending = 1'b0;
        chk(power_state, LPM_RUN);
    endtask

    // Stop with the RTC: slow clocks kept, peripheral fast clock request, RTC wake
    task automatic t_stop_rtc();
        rtc_en = 1'b1;
        lpm_core_model_inst.issue_wait(LPM_SEL_STOP);
        chk(power_state, LPM_STOP);
        chk({pll_en, multispeed_internal_osc_en, high_speed_external_clock_en,
             high_speed_internal_osc_en}, 4'h0);
        chk({low_speed_external_osc_en, low_speed_internal_osc_en, regulator_lp,
             ram_retain, periph_clk_en, cpu_clk_en}, 6'h3C);
        periph_hs_osc_req = 1'b1;
        @(negedge sys_clk);
        chk(high_speed_internal_osc_en, 1'b1);
        rtc_evt = 5'h10;
        wait_run(35, 1'b1);
    endtask

    // Stop without the RTC: all sources, comparator two gating
    task automatic t_stop_plain();
        rtc_en = 1'b0;
        independent_watchdog_en = 1'b1;
        lpm_core_model_inst.issue_wait(LPM_SEL_STOP);
        chk(low_speed_internal_osc_en, 1'b1);
        independent_watchdog_en = 1'b0;
        single_ev = 7'h04;
        rtc_evt = 5'h1F;
        repeat (3) @(negedge sys_clk);
        chk({power_state, low_speed_external_osc_en, low_speed_internal_osc_en},
            {LPM_STOP, 2'h0});
        rtc_evt = 5'h00;
        vref_on = 1'b1;
        wait_run(35, 1'b1);
        for (int i = 0; i < 8; i++) begin
            lpm_core_model_inst.issue_wait(LPM_SEL_STOP);
            if (i == 7)
                gpio_line = 16'h8000;
            else
                single_ev[i] = 1'b1;
            wait_run(35, 1'b1);
        end
    endtask

    // Standby with the RTC: power off, flag, every RTC event and watchdog
    task automatic t_standby_rtc();
        rtc_en = 1'b1;
        periph_hs_osc_req = 1'b1;
        lpm_core_model_inst.issue_wait(LPM_SEL_STANDBY);
        chk({regulator_off, pll_en, multispeed_internal_osc_en,
             high_speed_external_clock_en, high_speed_internal_osc_en,
             low_speed_external_osc_en, ram_retain, core_reset_n}, 8'h84);
        @(negedge sys_clk);
        chk(standby_flag, 1'b1);
        independent_watchdog_reset = 1'b1;
        wait_run(600, 1'b0);
        standby_flag_clr = 1'b1;
        @(negedge sys_clk);
        standby_flag_clr = 1'b0;
        chk(standby_flag, 1'b0);
        for (int j = 0; j < 5; j++) begin
            lpm_core_model_inst.issue_wait(LPM_SEL_STANDBY);
            rtc_evt[j] = 1'b1;
            wait_run(600, 1'b0);
        end
    endtask

    // Standby without the RTC: only pin edge or external reset
    task automatic t_standby_plain();
        rtc_en = 1'b0;
        lpm_core_model_inst.issue_wait(LPM_SEL_STANDBY);
        rtc_evt = 5'h1F;
        independent_watchdog_reset = 1'b1;
        gpio_line = 16'hFFFF;
        repeat (3) @(negedge sys_clk);
        chk({power_state, low_speed_external_osc_en, low_speed_internal_osc_en},
            {LPM_STANDBY, 2'h0});
        clear_ev();
        @(negedge sys_clk);
        wakeup_pin = 3'h4;
        wait_run(600, 1'b0);
        lpm_core_model_inst.issue_wait(LPM_SEL_STANDBY);
        external_reset_pin_n = 1'b0;
        wait_run(600, 1'b0);
    endtask

    // Main sequence
    initial begin
        {lp_run_req, rtc_en, independent_watchdog_en, vref_on, standby_flag_clr} = 5'h00;
        range_sel = LPM_RANGE3;
        osc_req = 6'h3F;
        clear_ev();
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        chk({power_state, cpu_clk_en, ram_retain, core_reset_n}, {LPM_RUN, 3'h7});
        t_flash();
        t_lprun();
        t_sleep();
        t_stop_rtc();
        t_stop_plain();
        t_standby_rtc();
        t_standby_plain();
        results();
    end
endmodule // tb_low_power_mode_controller
